// file: rsq_reset_sequencer.sv
// reset sequencer: merges reset sources, gates oscillator, runs the stabilization wait
`timescale 1ns/100ps
module rsq_reset_sequencer (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ext_reset_n,
  input  wire logic        por_low,
  input  wire logic        supply_drop,
  input  wire logic        stack_fault,
  input  wire logic        int_pin,
  input  wire logic        enable_wr,
  input  wire logic        enable_wdata,
  output logic             osc_enable,
  output logic             cpu_reset,
  output logic             cpu_run,
  output logic [9:0]       pc_start,
  output logic [3:0]       stack_pointer_reg,
  output logic             int_flag,
  output logic             supply_drop_reset_enable,
  output logic             in_wait
);
  typedef struct packed {
    rsq_pkg::rsq_state_t state;
    logic                osc_en;
    logic                cpu_rst;
    logic                run;
    logic [9:0]          pc;
    logic [3:0]          sp;
    logic                intf;
    logic                pdr_en;
    logic                waiting;
  } rsq_st_t;

  rsq_st_t st_reg;
  rsq_st_t st_next;
  logic    hard_rst;
  logic    tmr_done;
  logic    tmr_clear;
  logic    tmr_en;

  ////////////////////////////////////////////////////////////////////////////
  // reset sources; por and supply drop act with no oscillator dependence
  always_comb begin
    hard_rst = !ext_reset_n || por_low || (st_reg.pdr_en && supply_drop);
  end

  always_comb begin
    tmr_clear = hard_rst;
    tmr_en    = (st_reg.state == rsq_pkg::RSQ_WAIT) && !hard_rst;
  end

  rsq_wait_timer u_timer (
    .clk      (clk),
    .rst_n    (rst_n),
    .clear    (tmr_clear),
    .count_en (tmr_en),
    .done     (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    if (enable_wr && st_reg.run) begin
      st_next.pdr_en = enable_wdata;
    end
    if (hard_rst) begin
      st_next.state   = rsq_pkg::RSQ_HOLD;
      st_next.osc_en  = 1'b0;
      st_next.cpu_rst = 1'b1;
      st_next.run     = 1'b0;
      st_next.pc      = rsq_pkg::START_ADDR;
      st_next.sp      = rsq_pkg::SP_RESET_VALUE;
      st_next.intf    = int_pin;
      // the drop detector's own enable survives so a lasting drop keeps holding reset
      st_next.pdr_en  = st_reg.pdr_en;
    end else begin
      case (st_reg.state)
        rsq_pkg::RSQ_HOLD: begin
          st_next.state  = rsq_pkg::RSQ_WAIT;
          st_next.osc_en = 1'b1;
        end
        rsq_pkg::RSQ_WAIT: begin
          if (tmr_done) begin
            st_next.state   = rsq_pkg::RSQ_RUN;
            st_next.cpu_rst = 1'b0;
            st_next.run     = 1'b1;
            st_next.pc      = rsq_pkg::START_ADDR;
          end
        end
        rsq_pkg::RSQ_INIT: begin
          st_next.state   = rsq_pkg::RSQ_RUN;
          st_next.cpu_rst = 1'b0;
          st_next.run     = 1'b1;
        end
        rsq_pkg::RSQ_RUN: begin
          if (stack_fault) begin
            st_next.state   = rsq_pkg::RSQ_INIT;
            st_next.cpu_rst = 1'b1;
            st_next.run     = 1'b0;
            st_next.pc      = rsq_pkg::START_ADDR;
            st_next.sp      = rsq_pkg::SP_RESET_VALUE;
            st_next.intf    = int_pin;
            st_next.pdr_en  = 1'b0;
          end
        end
        default: begin
          st_next.state = rsq_pkg::RSQ_HOLD;
        end
      endcase
    end
    // wait flag kept in a flop so the output carries no decode glitch
    st_next.waiting = (st_next.state == rsq_pkg::RSQ_WAIT);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg.state   <= rsq_pkg::RSQ_HOLD;
      st_reg.osc_en  <= 1'b0;
      st_reg.cpu_rst <= 1'b1;
      st_reg.run     <= 1'b0;
      st_reg.pc      <= rsq_pkg::START_ADDR;
      st_reg.sp      <= rsq_pkg::SP_RESET_VALUE;
      st_reg.intf    <= 1'b0;
      st_reg.pdr_en  <= 1'b0;
      st_reg.waiting <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign osc_enable               = st_reg.osc_en;
  assign cpu_reset                = st_reg.cpu_rst;
  assign cpu_run                  = st_reg.run;
  assign pc_start                 = st_reg.pc;
  assign stack_pointer_reg        = st_reg.sp;
  assign int_flag                 = st_reg.intf;
  assign supply_drop_reset_enable = st_reg.pdr_en;
  assign in_wait                  = st_reg.waiting;

  ////////////////////////////////////////////////////////////////////////////
  AST_EXT_OSC_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    !ext_reset_n |=> !osc_enable && cpu_reset)
    else $error("external reset did not stop the core");
  AST_POR_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    por_low |=> cpu_reset && !cpu_run)
    else $error("por did not hold reset");
  AST_POR_OSC: assert property (@(posedge clk) disable iff (!rst_n)
    por_low |=> !osc_enable)
    else $error("oscillator ran during por");
  AST_PDR_OSC: assert property (@(posedge clk) disable iff (!rst_n)
    (supply_drop && supply_drop_reset_enable) |=> !osc_enable && cpu_reset)
    else $error("supply drop reset missed");
  AST_PDR_DISABLED: assert property (@(posedge clk) disable iff (!rst_n)
    (cpu_run && ext_reset_n && !por_low && !supply_drop_reset_enable && !stack_fault) |=> cpu_run)
    else $error("disabled drop detector reset the core");
  AST_RELEASE_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(hard_rst) && st_reg.state == rsq_pkg::RSQ_HOLD) |=> osc_enable && in_wait ##1 !cpu_run [*8])
    else $error("release did not start the wait");
  AST_STACK_SKIP: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.state == rsq_pkg::RSQ_RUN && stack_fault && !hard_rst) |=> cpu_reset ##1 (cpu_run || $past(hard_rst)))
    else $error("stack reset did not skip the wait");
  AST_PC_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(cpu_run) |-> pc_start == rsq_pkg::START_ADDR)
    else $error("run began away from address zero");
  AST_SP_INIT: assert property (@(posedge clk) disable iff (!rst_n)
    hard_rst |=> stack_pointer_reg == rsq_pkg::SP_RESET_VALUE && int_flag == $past(int_pin))
    else $error("initial state not loaded");
  AST_WAIT_HELD: assert property (@(posedge clk) disable iff (!rst_n)
    in_wait |-> osc_enable && cpu_reset && !cpu_run)
    else $error("core left reset during the wait");
  AST_RUN_CLEAN: assert property (@(posedge clk) disable iff (!rst_n)
    cpu_run |-> osc_enable && !cpu_reset && !in_wait)
    else $error("core ran while held or waiting");
  AST_STACK_CLEARS_EN: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.state == rsq_pkg::RSQ_RUN && stack_fault && !hard_rst) |=> !supply_drop_reset_enable)
    else $error("stack reset kept the drop enable");
  AST_EN_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    (enable_wr && cpu_run && !hard_rst && !stack_fault) |=> supply_drop_reset_enable == $past(enable_wdata))
    else $error("drop enable write lost");
  AST_EN_REFUSED: assert property (@(posedge clk) disable iff (!rst_n)
    (enable_wr && !cpu_run) |=> supply_drop_reset_enable == $past(supply_drop_reset_enable))
    else $error("drop enable written outside run");
  AST_EN_KEPT_HARD: assert property (@(posedge clk) disable iff (!rst_n)
    hard_rst |=> supply_drop_reset_enable == $past(supply_drop_reset_enable))
    else $error("hard reset changed the drop enable");

  COV_FULL_WAIT: cover property (@(posedge clk) disable iff (!rst_n) in_wait ##1 $rose(cpu_run));
  COV_STACK: cover property (@(posedge clk) disable iff (!rst_n) stack_fault && cpu_run);
  COV_PDR: cover property (@(posedge clk) disable iff (!rst_n) supply_drop && supply_drop_reset_enable);
  COV_RESTART: cover property (@(posedge clk) disable iff (!rst_n) in_wait ##1 hard_rst);
endmodule : rsq_reset_sequencer

// file: rsq_pkg.sv
// package: constants and types of the reset sequencer
// How it works
// - releasing external reset starts the clock, then a timer stabilization wait runs
// - every completed reset sequence starts execution at program address zero
// - power-on reset follows exactly the external reset sequence, wait included
// - stack overflow/underflow reset skips the wait, sets initial state, restarts at zero
// - the stabilization wait lasts 256 times 256 system clocks
// - power-on reset initializes regardless of oscillator or software state
// - internal reset is held while the power-on detector reports low supply
// - oscillator is kept stopped while power-on reset is asserted
// - after power-on reset ends, the timer counts to the fixed value before running
// - supply drop reset acts only while software holds its enable flag set
// - enabled supply drop detection asserts internal reset and initializes state
// - oscillator is kept stopped while supply drop reset is asserted
// - after supply recovery the wait runs, then execution resumes from address zero
// - hard resets load stack pointer 5H, sample interrupt pin, keep the supply drop enable flag
package rsq_pkg;
  localparam int        WAIT_BASE       = 256;
  localparam int        WAIT_CYCLES     = WAIT_BASE * WAIT_BASE;
  localparam int        CNT_W           = 17;
  localparam logic [3:0] SP_RESET_VALUE = 4'h5;
  localparam logic [9:0] START_ADDR     = 10'h000;

  typedef enum logic [1:0] {
    RSQ_HOLD = 2'b00,
    RSQ_WAIT = 2'b01,
    RSQ_INIT = 2'b10,
    RSQ_RUN  = 2'b11
  } rsq_state_t;
endpackage : rsq_pkg

// file: rsq_wait_timer.sv
// stabilization wait timer: counts system clocks while enabled
`timescale 1ns/100ps
module rsq_wait_timer (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clear,
  input  wire logic count_en,
  output logic      done
);
  typedef struct packed {
    logic [rsq_pkg::CNT_W-1:0] cnt;
    logic                      done;
  } rsq_tmr_t;

  rsq_tmr_t st_reg;
  rsq_tmr_t st_next;

  always_comb begin
    st_next = st_reg;
    if (clear) begin
      st_next = '0;
    end else if (count_en && !st_reg.done) begin
      st_next.cnt  = st_reg.cnt + 17'h00001;
      st_next.done = (st_reg.cnt == 17'(rsq_pkg::WAIT_CYCLES - 1));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign done = st_reg.done;

  AST_DONE_AFTER_FULL: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(done) |-> st_reg.cnt == 17'(rsq_pkg::WAIT_CYCLES))
    else $error("wait ended at wrong count");
  AST_CLEAR_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    clear |=> (st_reg.cnt == 17'h00000 && !done))
    else $error("clear did not zero the timer");
endmodule : rsq_wait_timer

// file: rsq_supply_model.sv
// partner model: external reset pin driver and supply voltage detectors
`timescale 1ns/100ps
module rsq_supply_model (
  input  wire logic clk,
  input  wire logic ext_req,
  input  wire logic por_req,
  input  wire logic drop_req,
  output logic      ext_reset_n,
  output logic      por_low,
  output logic      supply_drop
);
  initial begin
    ext_reset_n = 1'b1;
    por_low     = 1'b0;
    supply_drop = 1'b0;
  end
  // detectors settle just after an edge, like slow analog comparators
  always @(posedge clk) begin
    ext_reset_n <= !ext_req;
    por_low     <= por_req;
    supply_drop <= drop_req;
  end
endmodule : rsq_supply_model

// file: reset_sequencer_with_osc_wait_tb.sv
// testbench of the reset sequencer
`timescale 1ns/100ps
module reset_sequencer_with_osc_wait_tb;
  logic       clk, rst_n, ext_req, por_req, drop_req, stack_fault, int_pin, enable_wr, enable_wdata, ip;
  logic       ext_reset_n, por_low, supply_drop, osc_enable, cpu_reset, cpu_run, int_flag, sde, in_wait;
  logic [9:0] pc_start;
  logic [3:0] sp;
  int         failures, samples_checked, cyc, n;

  rsq_supply_model u_sup (.clk(clk), .ext_req(ext_req), .por_req(por_req), .drop_req(drop_req),
    .ext_reset_n(ext_reset_n), .por_low(por_low), .supply_drop(supply_drop));
  rsq_reset_sequencer u_dut (.clk(clk), .rst_n(rst_n), .ext_reset_n(ext_reset_n), .por_low(por_low),
    .supply_drop(supply_drop), .stack_fault(stack_fault), .int_pin(int_pin), .enable_wr(enable_wr),
    .enable_wdata(enable_wdata), .osc_enable(osc_enable), .cpu_reset(cpu_reset), .cpu_run(cpu_run),
    .pc_start(pc_start), .stack_pointer_reg(sp), .int_flag(int_flag), .supply_drop_reset_enable(sde),
    .in_wait(in_wait));

  always #5 clk = ~clk;
  // the full stabilization wait dominates the run time
  always @(posedge clk) begin
    cyc++;
    if (cyc > 70000) begin
      failures++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic int exp_wait();
    return rsq_pkg::WAIT_CYCLES + 1;
  endfunction : exp_wait
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic write_enable(input logic v);
    @(posedge clk) begin
      enable_wr    <= 1'b1;
      enable_wdata <= v;
    end
    @(posedge clk) enable_wr <= 1'b0;
    tick(1);
  endtask : write_enable
  task automatic check_bit(input logic got, input logic exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value t=%0t %s", $time, msg);
    end
  endtask : check_bit
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value t=%0t %s got %0h", $time, msg, got);
    end
  endtask : check_val
  task automatic final_report();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0; rst_n = 0; ext_req = 0; por_req = 1; drop_req = 0; stack_fault = 0;
    enable_wr = 0; enable_wdata = 0; cyc = 0; failures = 0; samples_checked = 0;
    void'($urandom(90256));
    ip = 1'($urandom_range(1, 0));
    int_pin = ip;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    tick(20);
    check_bit(osc_enable, 1'b0, "oscillator runs under power-on");
    check_bit(cpu_reset, 1'b1, "core free under power-on");
    @(posedge clk) por_req <= 1'b0;
    tick(3);
    check_bit(in_wait, 1'b1, "no wait after power-on");
    check_bit(int_flag, ip, "interrupt pin not captured");
    tick(100);
    // a pin reset in mid-wait must restart the count from zero
    @(posedge clk) ext_req <= 1'b1;
    tick(3);
    check_bit(osc_enable, 1'b0, "oscillator runs under pin reset");
    check_bit(in_wait, 1'b0, "wait continues under pin reset");
    @(posedge clk) ext_req <= 1'b0;
    n = 0;
    while (in_wait !== 1'b1 && n < 10) begin tick(1); n++; end
    n = 0;
    while (cpu_run !== 1'b1 && n < 70000) begin tick(1); n++; end
    check_val(n, exp_wait(), "wait length");
    check_val(pc_start, rsq_pkg::START_ADDR, "start address");
    check_val(sp, rsq_pkg::SP_RESET_VALUE, "stack pointer");
    check_bit(cpu_reset, 1'b0, "core still held after wait");
    repeat (40) begin
      @(posedge clk);
      ip = 1'($urandom_range(1, 0));
      drop_req <= 1'($urandom_range(1, 0));
      int_pin  <= ip;
    end
    @(posedge clk) drop_req <= 1'b0;
    tick(2);
    check_bit(cpu_run, 1'b1, "drop acted while disabled");
    write_enable(1'b1);
    check_bit(sde, 1'b1, "enable not written");
    @(posedge clk) stack_fault <= 1'b1;
    @(posedge clk) stack_fault <= 1'b0;
    #1;
    check_bit(cpu_reset, 1'b1, "stack fault ignored");
    check_bit(osc_enable, 1'b1, "stack fault stopped oscillator");
    tick(3);
    check_bit(cpu_run, 1'b1, "stack reset waited");
    check_val(pc_start, rsq_pkg::START_ADDR, "start after stack reset");
    check_bit(int_flag, ip, "pin not captured by stack reset");
    check_bit(sde, 1'b0, "stack reset kept enable");
    write_enable(1'b1);
    check_bit(sde, 1'b1, "enable not rewritten");
    @(posedge clk) drop_req <= 1'b1;
    tick(3);
    check_bit(cpu_reset, 1'b1, "drop did not reset");
    check_bit(osc_enable, 1'b0, "oscillator runs under drop");
    check_bit(int_flag, ip, "pin not captured by drop reset");
    @(posedge clk) drop_req <= 1'b0;
    tick(3);
    check_bit(in_wait, 1'b1, "no wait after recovery");
    check_bit(sde, 1'b1, "drop reset lost enable");
    write_enable(1'b0);
    check_bit(sde, 1'b1, "enable written outside run");
    final_report();
  end
endmodule : reset_sequencer_with_osc_wait_tb
